// ==== debug_port_pkg.sv ====
package debug_port_pkg;
   localparam logic [7:0]  CTRL_OFFSET     = 8'h20;
   localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
   localparam int          EN_BIT          = 0;
   localparam int          ROUTE_LSB       = 1;
   localparam int          ROUTE_MSB       = 2;
   localparam int          PULLUP_BIT      = 3;
   localparam int          NUM_PINS        = 4;
   localparam logic [1:0]  ROUTE_ALL4      = 2'h0;
   localparam logic [1:0]  ROUTE_NO_TDI    = 2'h1;
   localparam logic [1:0]  ROUTE_CLK_MODE  = 2'h2;
   localparam logic [1:0]  ROUTE_RESERVED  = 2'h3;
   // Pin order in the routing vectors
   localparam int          PIN_TCK         = 0;
   localparam int          PIN_TMS         = 1;
   localparam int          PIN_TDI         = 2;
   localparam int          PIN_TDO         = 3;
   localparam logic [3:0]  MASK_ALL4       = 4'hF;
   localparam logic [3:0]  MASK_NO_TDI     = 4'hB;
   localparam logic [3:0]  MASK_CLK_MODE   = 4'h3;
   localparam logic [3:0]  MASK_NONE       = 4'h0;
endpackage

// ==== debug_pin_mux.sv ====
`timescale 1ns/1ps
module debug_pin_mux (
   input  wire logic       i_sys_clk,
   input  wire logic       i_sys_rst,
   input  wire logic       i_port_active,
   input  wire logic       i_pullup_en,
   input  wire logic [1:0] i_route,
   output logic      [3:0] o_pin_to_debug,
   output logic      [3:0] o_pin_pullup
);
   logic [3:0] mask;

   // Per-routing pin selection
   always_comb begin
      unique case (i_route)
         debug_port_pkg::ROUTE_ALL4:     mask = debug_port_pkg::MASK_ALL4;
         debug_port_pkg::ROUTE_NO_TDI:   mask = debug_port_pkg::MASK_NO_TDI;
         debug_port_pkg::ROUTE_CLK_MODE: mask = debug_port_pkg::MASK_CLK_MODE;
         debug_port_pkg::ROUTE_RESERVED: mask = debug_port_pkg::MASK_NONE;
      endcase
   end

   genvar g;
   generate
      for (g = 0; g < debug_port_pkg::NUM_PINS; g++) begin : g_pin
         always_ff @(posedge i_sys_clk) begin
            if (i_sys_rst) begin
               o_pin_to_debug[g] <= 1'b0;
               o_pin_pullup[g]   <= 1'b0;
            end else begin
               o_pin_to_debug[g] <= i_port_active & mask[g];
               o_pin_pullup[g]   <= i_port_active & i_pullup_en & mask[g];
            end
         end
      end
   endgenerate
endmodule // debug_pin_mux

// ==== debug_port_ctrl.sv ====
`timescale 1ns/1ps
module debug_port_ctrl (
   input  wire logic        i_sys_clk,
   input  wire logic        i_sys_rst,
   input  wire logic [7:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [31:0] o_rdata,
   input  wire logic        i_trst,
   input  wire logic        i_swd_select,
   output logic             o_port_active,
   output logic             o_jtag_mode,
   output logic             o_swd_mode,
   output logic      [3:0]  o_pin_to_debug,
   output logic      [3:0]  o_pin_pullup
);
   logic       enable_reg;
   logic [1:0] route_reg;
   logic       pullup_reg;
   logic       active_next;

   // Control register write
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         enable_reg <= debug_port_pkg::CTRL_RESET[debug_port_pkg::EN_BIT];
         route_reg  <= debug_port_pkg::CTRL_RESET[debug_port_pkg::ROUTE_MSB:
                                                  debug_port_pkg::ROUTE_LSB];
         pullup_reg <= debug_port_pkg::CTRL_RESET[debug_port_pkg::PULLUP_BIT];
      end else if (i_wr && i_addr == debug_port_pkg::CTRL_OFFSET) begin
         enable_reg <= i_wdata[debug_port_pkg::EN_BIT];
         route_reg  <= i_wdata[debug_port_pkg::ROUTE_MSB:debug_port_pkg::ROUTE_LSB];
         pullup_reg <= i_wdata[debug_port_pkg::PULLUP_BIT];
      end
   end

   // Read data one cycle after strobe, zero elsewhere
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_rdata <= 32'h0000_0000;
      end else if (i_rd && i_addr == debug_port_pkg::CTRL_OFFSET) begin
         o_rdata <= {28'h000_0000, pullup_reg, route_reg, enable_reg};
      end else begin
         o_rdata <= 32'h0000_0000;
      end
   end

   assign active_next = enable_reg & i_trst;

   // Port activation and mode
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_port_active <= 1'b0;
         o_jtag_mode   <= 1'b0;
         o_swd_mode    <= 1'b0;
      end else begin
         o_port_active <= active_next;
         o_jtag_mode   <= active_next & ~i_swd_select;
         o_swd_mode    <= active_next & i_swd_select;
      end
   end

   debug_pin_mux u_mux (
      .i_sys_clk      (i_sys_clk),
      .i_sys_rst      (i_sys_rst),
      .i_port_active  (active_next),
      .i_pullup_en    (pullup_reg),
      .i_route        (route_reg),
      .o_pin_to_debug (o_pin_to_debug),
      .o_pin_pullup   (o_pin_pullup)
   );

   property p_disabled_gpio;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         !enable_reg |=> (o_pin_to_debug == 4'h0 && !o_port_active);
   endproperty
   a_disabled_gpio: assert property (p_disabled_gpio)
      else $error("pins routed while disabled");

   property p_active;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (enable_reg && i_trst) |=> o_port_active;
   endproperty
   a_active: assert property (p_active)
      else $error("port not active");

   property p_route0;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (active_next && route_reg == 2'h0) |=> o_pin_to_debug == 4'hF;
   endproperty
   a_route0: assert property (p_route0)
      else $error("route 0 wrong");

   property p_route1;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (active_next && route_reg == 2'h1) |=> o_pin_to_debug == 4'hB;
   endproperty
   a_route1: assert property (p_route1)
      else $error("route 1 wrong");

   property p_route2;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (active_next && route_reg == 2'h2) |=> o_pin_to_debug == 4'h3;
   endproperty
   a_route2: assert property (p_route2)
      else $error("route 2 wrong");

   property p_pullup_on;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (active_next && pullup_reg) |=> (o_pin_pullup != 4'h0 || $past(route_reg) == 2'h3);
   endproperty
   a_pullup_on: assert property (p_pullup_on)
      else $error("pull-ups missing");

   property p_pullup_subset;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (o_pin_pullup & ~o_pin_to_debug) == 4'h0;
   endproperty
   a_pullup_subset: assert property (p_pullup_subset)
      else $error("pull-up on non-debug pin");

   property p_release;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         !i_trst |=> (o_pin_to_debug == 4'h0 && o_pin_pullup == 4'h0);
   endproperty
   a_release: assert property (p_release)
      else $error("pins not released");

   property p_reset_outputs;
      @(posedge i_sys_clk)
         i_sys_rst |=> (!o_port_active && o_pin_to_debug == debug_port_pkg::MASK_NONE &&
                        o_pin_pullup == debug_port_pkg::MASK_NONE);
   endproperty
   a_reset_outputs: assert property (p_reset_outputs)
      else $error("outputs not cleared by reset");

   property p_reset_ctrl;
      @(posedge i_sys_clk)
         i_sys_rst |=> ({pullup_reg, route_reg, enable_reg} ==
                        debug_port_pkg::CTRL_RESET[3:0] && o_rdata == 32'h0000_0000);
   endproperty
   a_reset_ctrl: assert property (p_reset_ctrl)
      else $error("control register not cleared by reset");

   property p_write_ctrl;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (i_wr && i_addr == debug_port_pkg::CTRL_OFFSET) |=>
            ({28'h000_0000, pullup_reg, route_reg, enable_reg} == ($past(i_wdata) & 32'h0000_000F));
   endproperty
   a_write_ctrl: assert property (p_write_ctrl)
      else $error("control write not taken");

   property p_write_ignored;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         !(i_wr && i_addr == debug_port_pkg::CTRL_OFFSET) |=> $stable({pullup_reg, route_reg, enable_reg});
   endproperty
   a_write_ignored: assert property (p_write_ignored)
      else $error("control changed without write");

   property p_read_fields;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (i_rd && i_addr == debug_port_pkg::CTRL_OFFSET) |=>
            (o_rdata[debug_port_pkg::EN_BIT] == $past(enable_reg) &&
             o_rdata[debug_port_pkg::ROUTE_MSB:debug_port_pkg::ROUTE_LSB] == $past(route_reg) &&
             o_rdata[debug_port_pkg::PULLUP_BIT] == $past(pullup_reg));
   endproperty
   a_read_fields: assert property (p_read_fields)
      else $error("read data fields wrong");

   property p_read_zero;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         !(i_rd && i_addr == debug_port_pkg::CTRL_OFFSET) |=> o_rdata == 32'h0000_0000;
   endproperty
   a_read_zero: assert property (p_read_zero)
      else $error("read data not zero");

   property p_read_reserved;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         o_rdata[31:4] == 28'h000_0000;
   endproperty
   a_read_reserved: assert property (p_read_reserved)
      else $error("reserved bits read nonzero");

   property p_trst_ignored;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (!enable_reg && i_trst) |=> !o_port_active;
   endproperty
   a_trst_ignored: assert property (p_trst_ignored)
      else $error("reset pin not ignored");

   property p_no_mode_disabled;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         !enable_reg |=> (!o_jtag_mode && !o_swd_mode);
   endproperty
   a_no_mode_disabled: assert property (p_no_mode_disabled)
      else $error("mode set while disabled");

   property p_jtag_mode;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (active_next && !i_swd_select) |=> (o_jtag_mode && !o_swd_mode);
   endproperty
   a_jtag_mode: assert property (p_jtag_mode)
      else $error("jtag mode missing");

   property p_swd_mode;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (active_next && i_swd_select) |=> (o_swd_mode && !o_jtag_mode);
   endproperty
   a_swd_mode: assert property (p_swd_mode)
      else $error("serial wire mode missing");

   property p_mode_onehot;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         ((o_jtag_mode | o_swd_mode) == o_port_active) && !(o_jtag_mode && o_swd_mode);
   endproperty
   a_mode_onehot: assert property (p_mode_onehot)
      else $error("mode outputs inconsistent");

   property p_swd_select;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         o_swd_mode |-> $past(i_swd_select);
   endproperty
   a_swd_select: assert property (p_swd_select)
      else $error("serial wire mode without select");

   property p_jtag_select;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         o_jtag_mode |-> !$past(i_swd_select);
   endproperty
   a_jtag_select: assert property (p_jtag_select)
      else $error("jtag mode with select set");

   property p_inactive;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         !active_next |=> !o_port_active;
   endproperty
   a_inactive: assert property (p_inactive)
      else $error("port still active");

   property p_fell_release;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         $fell(active_next) |=> (o_pin_to_debug == debug_port_pkg::MASK_NONE &&
                                 o_pin_pullup == debug_port_pkg::MASK_NONE);
   endproperty
   a_fell_release: assert property (p_fell_release)
      else $error("pins kept after deactivation");

   property p_enable_clear;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         !enable_reg |=> o_pin_pullup == debug_port_pkg::MASK_NONE;
   endproperty
   a_enable_clear: assert property (p_enable_clear)
      else $error("pull-ups kept while disabled");

   property p_tck_tms;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (active_next && route_reg != debug_port_pkg::ROUTE_RESERVED) |=>
            (o_pin_to_debug[debug_port_pkg::PIN_TCK] && o_pin_to_debug[debug_port_pkg::PIN_TMS]);
   endproperty
   a_tck_tms: assert property (p_tck_tms)
      else $error("clock or mode pin not routed");

   property p_tdo_route;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (active_next && (route_reg == debug_port_pkg::ROUTE_ALL4 ||
                          route_reg == debug_port_pkg::ROUTE_NO_TDI)) |=>
            o_pin_to_debug[debug_port_pkg::PIN_TDO];
   endproperty
   a_tdo_route: assert property (p_tdo_route)
      else $error("data out pin not routed");

   property p_route_reserved;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (active_next && route_reg == debug_port_pkg::ROUTE_RESERVED) |=>
            (o_pin_to_debug == debug_port_pkg::MASK_NONE &&
             o_pin_pullup == debug_port_pkg::MASK_NONE);
   endproperty
   a_route_reserved: assert property (p_route_reserved)
      else $error("reserved routing moved pins");

   property p_pins_need_active;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (o_pin_to_debug != debug_port_pkg::MASK_NONE) |-> o_port_active;
   endproperty
   a_pins_need_active: assert property (p_pins_need_active)
      else $error("pins routed while inactive");

   property p_pullup_match;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (active_next && pullup_reg) |=> o_pin_pullup == o_pin_to_debug;
   endproperty
   a_pullup_match: assert property (p_pullup_match)
      else $error("pull-ups differ from routed pins");

   property p_pullup_off;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (active_next && !pullup_reg) |=> o_pin_pullup == debug_port_pkg::MASK_NONE;
   endproperty
   a_pullup_off: assert property (p_pullup_off)
      else $error("pull-ups on with bit clear");

   property p_pull_needs_bit;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (o_pin_pullup != debug_port_pkg::MASK_NONE) |-> $past(pullup_reg);
   endproperty
   a_pull_needs_bit: assert property (p_pull_needs_bit)
      else $error("pull-up without enable bit");

   property p_pull_tdi;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (active_next && pullup_reg && route_reg != debug_port_pkg::ROUTE_ALL4) |=>
            !o_pin_pullup[debug_port_pkg::PIN_TDI];
   endproperty
   a_pull_tdi: assert property (p_pull_tdi)
      else $error("pull-up on data in pin");
endmodule // debug_port_ctrl

// ==== debug_probe_model.sv ====
`timescale 1ns/1ps
module debug_probe_model (
   input  wire logic i_sys_clk,
   input  wire logic i_attach,
   input  wire logic i_swd,
   output logic      o_trst,
   output logic      o_swd_select
);
   // Probe drives its pins just after the clock edge
   always_ff @(posedge i_sys_clk) begin
      o_trst       <= i_attach;
      o_swd_select <= i_swd;
   end
endmodule // debug_probe_model

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
   logic        i_sys_clk = 1'b0;
   logic        i_sys_rst = 1'b1;
   logic [7:0]  i_addr    = 8'h00;
   logic [31:0] i_wdata   = 32'h0;
   logic        i_wr      = 1'b0;
   logic        i_rd      = 1'b0;
   logic        attach    = 1'b0;
   logic        swd       = 1'b0;
   logic        trst, swd_sel, act, jtag, swdm;
   logic [31:0] rdata;
   logic [3:0]  to_dbg, pull;
   logic [15:0] lfsr_reg  = 16'h0042;
   int          miscompares = 0;
   int          compares    = 0;
   int          ctrl        = 0;
   int          e_act, e_jtag, e_swd, e_rd, e_dbg, e_pull;
   always #2.5 i_sys_clk = ~i_sys_clk;
   debug_probe_model probe (.i_sys_clk(i_sys_clk), .i_attach(attach), .i_swd(swd),
      .o_trst(trst), .o_swd_select(swd_sel));
   debug_port_ctrl dut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_trst(trst),
      .i_swd_select(swd_sel), .o_port_active(act), .o_jtag_mode(jtag), .o_swd_mode(swdm),
      .o_pin_to_debug(to_dbg), .o_pin_pullup(pull));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic int route_mask(input int r);
      return (r == 0) ? 15 : (r == 1) ? 11 : (r == 2) ? 3 : 0;
   endfunction
   // Reference model, one step per clock edge
   always @(posedge i_sys_clk) begin
      e_act  = i_sys_rst ? 0 : (ctrl & 1) & trst;
      e_jtag = e_act & !swd_sel;
      e_swd  = e_act & swd_sel;
      e_dbg  = e_act ? route_mask((ctrl >> 1) & 3) : 0;
      e_pull = ((ctrl >> 3) & 1) ? e_dbg : 0;
      e_rd   = (!i_sys_rst && i_rd && i_addr == 8'h20) ? ctrl : 0;
      if (i_sys_rst) ctrl = 0;
      else if (i_wr && i_addr == 8'h20) ctrl = i_wdata[3:0];
   end
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   always @(negedge i_sys_clk) begin
      if (!i_sys_rst) begin
         check("active", act, e_act);
         check("jtag", jtag, e_jtag);
         check("swd", swdm, e_swd);
         check("to_debug", to_dbg, e_dbg);
         check("pullup", pull, e_pull);
         check("rdata", rdata, e_rd);
      end
   end
   task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_sys_clk);
      i_wr    <= w;
      i_rd    <= r;
      i_addr  <= a;
      i_wdata <= d;
   endtask
   task automatic tally_and_finish;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge i_sys_clk);
      i_sys_rst <= 1'b0;
      // Every control value, probe attached and detached
      for (int v = 0; v < 32; v++) begin
         bus(1'b1, 1'b0, 8'h20, {28'hFFFFFFF, v[3:0]});
         attach <= v[4];
         swd    <= v[1] | v[2];
         bus(1'b0, 1'b1, 8'h20, 32'h0);
         bus(1'b0, 1'b0, 8'h20, 32'h0);
         bus(1'b0, 1'b0, 8'h00, 32'h0);
      end
      bus(1'b1, 1'b0, 8'h24, 32'h0000000F);
      bus(1'b0, 1'b1, 8'h21, 32'h0);
      bus(1'b0, 1'b1, 8'h20, 32'h0);
      $display("directed sweep done");
      bus(1'b0, 1'b0, 8'h00, 32'h0);
      i_sys_rst <= 1'b1;
      repeat (2) @(posedge i_sys_clk);
      i_sys_rst <= 1'b0;
      bus(1'b0, 1'b1, 8'h20, 32'h0);
      bus(1'b0, 1'b0, 8'h00, 32'h0);
      $display("mid-run reset done");
      for (int n = 0; n < 600; n++) begin
         lfsr_reg = lfsr(lfsr_reg);
         bus(lfsr_reg[0], !lfsr_reg[0] && lfsr_reg[1], lfsr_reg[2] ? 8'h20 : lfsr_reg[15:8],
             {lfsr_reg, lfsr_reg[15:3], lfsr_reg[2] & ~lfsr_reg[1], lfsr_reg[1:0]});
         attach <= lfsr_reg[3] | lfsr_reg[4];
         swd    <= lfsr_reg[5];
      end
      bus(1'b0, 1'b0, 8'h00, 32'h0);
      repeat (2) @(posedge i_sys_clk);
      $display("random traffic done");
      tally_and_finish();
   end
endmodule // tb
